// ---- cal_params.svh ----
/*
 * Constants of the add/logic/branch datapath: register offsets,
 * status word bit positions, operand constants and reset values.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef CAL_PARAMS_SVH
`define CAL_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CAL_A_SRC   8'h00
`define CAL_A_DST   8'h04
`define CAL_A_CMD   8'h08
`define CAL_A_SW    8'h0C
`define CAL_A_PC    8'h10
`define CAL_A_SP    8'h14

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define CAL_SW_C    0
`define CAL_SW_Z    1
`define CAL_SW_N    2
`define CAL_SW_IE   3
`define CAL_SW_HLT  4
`define CAL_SW_OSC  5
`define CAL_SW_V    8

// ----------------------------------------
// operand constants and reset values
// ----------------------------------------
`define CAL_K_ZERO  16'h0000
`define CAL_K_CMSK  16'h0001
`define CAL_K_NMSK  16'h0004
`define CAL_SP_STEP 16'h0002
`define CAL_RST_W   16'h0000

`endif

// ---- cal_pkg.sv ----
/*
 * Types of the add/logic/branch datapath: operation codes,
 * command word, ALU answer and sequencer states.
 * Assumes nothing of its surroundings.
 */
package cal_pkg;

    typedef enum logic [3:0] {
        CAL_OP_COPY  = 4'h0,
        CAL_OP_ADD   = 4'h1,
        CAL_OP_ADDCI = 4'h2,
        CAL_OP_AND   = 4'h3,
        CAL_OP_BIT   = 4'h4,
        CAL_OP_BCLR  = 4'h5,
        CAL_OP_BSET  = 4'h6,
        CAL_OP_JUMP  = 4'h7,
        CAL_OP_CALL  = 4'h8,
        CAL_OP_ZERO  = 4'h9,
        CAL_OP_CCLR  = 4'hA,
        CAL_OP_NCLR  = 4'hB
    } cal_op_t;

    typedef struct packed {
        logic    byte_sel;
        cal_op_t op;
    } cal_cmd_t;

    typedef struct packed {
        logic [15:0] res;
        logic        n;
        logic        z;
        logic        c;
        logic        v;
        logic        flag_we;
        logic        dst_we;
    } cal_alu_t;

    typedef enum logic [2:0] {
        CAL_ST_IDLE = 3'b000,
        CAL_ST_EXEC = 3'b001,
        CAL_ST_DEC  = 3'b010,
        CAL_ST_PUSH = 3'b011,
        CAL_ST_LOAD = 3'b100
    } cal_state_t;

endpackage

// ---- cal_alu.sv ----
/*
 * Combinational ALU: sum, sum with carry, and, bit test,
 * clear bits, set bits and copy, in word or byte size.
 * Assumes operands and carry come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cal_params.svh"

module cal_alu (
    input  wire cal_pkg::cal_cmd_t cmd,
    input  wire logic [15:0]       a,
    input  wire logic [15:0]       b,
    input  wire logic              cin,
    output var  cal_pkg::cal_alu_t out
);

    logic [16:0] sum_w;
    logic [8:0]  sum_b;
    logic        ci;
    logic        am;
    logic        bm;

    always_comb begin
        out = '0;
        ci = (cmd.op == cal_pkg::CAL_OP_ADDCI) ? cin : 1'b0;
        sum_w = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
        sum_b = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, ci};
        // size bit picks word or byte
        am = cmd.byte_sel ? a[7] : a[15];
        bm = cmd.byte_sel ? b[7] : b[15];
        out.dst_we = (cmd.op != cal_pkg::CAL_OP_BIT);
        case (cmd.op)
            cal_pkg::CAL_OP_ADD,
            cal_pkg::CAL_OP_ADDCI: begin
                out.res = sum_w[15:0];
                out.c = cmd.byte_sel ? sum_b[8] : sum_w[16];
                out.flag_we = 1'b1;
            end
            cal_pkg::CAL_OP_AND,
            cal_pkg::CAL_OP_BIT: begin
                out.res = a & b;
                out.flag_we = 1'b1;
            end
            cal_pkg::CAL_OP_BCLR: out.res = ~a & b;
            cal_pkg::CAL_OP_BSET: out.res = a | b;
            default: out.res = a;
        endcase
        if (cmd.byte_sel) begin
            out.res[15:8] = 8'h00;
        end
        out.n = cmd.byte_sel ? out.res[7] : out.res[15];
        out.z = cmd.byte_sel ? (out.res[7:0] == 8'h00)
                             : (out.res == `CAL_K_ZERO);
        if (cmd.op == cal_pkg::CAL_OP_ADD || cmd.op == cal_pkg::CAL_OP_ADDCI) begin
            out.v = (am == bm) && (out.n != am);
        end else begin
            out.c = out.flag_we & ~out.z;
        end
    end

endmodule

`default_nettype wire

// ---- cal_core.sv ----
/*
 * Add/logic/branch execution unit with an APB register file:
 * operand, command, status word, program counter, stack pointer.
 * Assumes an APB master on pclk and a stack memory that takes
 * one write strobe with address and data.
 */
// Functional notes
// - sum writes destination, source kept
// - sum sets N Z C V
// - sum with carry adds carry flag
// - carry from top bit, others alike
// - and: N top, Z, C not Z, V clear
// - bit test sets flags only
// - clear bits, flags untouched
// - set bits, flags untouched
// - mode bits never altered
// - jump loads source into counter
// - call: temp, sp minus 2, push, load
// - call pushes following address, flags kept
// - zero destination is copy of zero
// - carry clear via bit clear of 1
// - negative clear ands with 0FFFBh
// - size bit: 0 word, 1 byte
`timescale 1ns/1ps
`default_nettype none
`include "cal_params.svh"

module cal_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        stack_we,
    output var  logic [15:0] stack_addr,
    output var  logic [15:0] stack_data
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [15:0]          src;
    logic [15:0]          dst;
    logic [15:0]          pc;
    logic [15:0]          sp;
    logic [15:0]          sw;
    logic [15:0]          tmp;
    cal_pkg::cal_cmd_t    cmd;
    cal_pkg::cal_state_t  state;
    cal_pkg::cal_state_t  next_state;
    cal_pkg::cal_cmd_t    alu_cmd;
    cal_pkg::cal_alu_t    alu;
    logic [15:0]          alu_a;
    logic [15:0]          alu_b;
    logic [15:0]          rd_val;
    logic                 hit;
    logic                 wr;
    logic                 ex;
    logic                 start;
    logic                 to_sw;
    logic                 w_src;
    logic                 w_dst;
    logic                 w_cmd;
    logic                 w_sw;
    logic                 w_pc;
    logic                 w_sp;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign wr    = psel & penable & pready & pwrite;
    assign w_src = wr && (paddr == `CAL_A_SRC);
    assign w_dst = wr && (paddr == `CAL_A_DST);
    assign w_cmd = wr && (paddr == `CAL_A_CMD);
    assign w_sw  = wr && (paddr == `CAL_A_SW);
    assign w_pc  = wr && (paddr == `CAL_A_PC);
    assign w_sp  = wr && (paddr == `CAL_A_SP);
    assign ex    = (state == cal_pkg::CAL_ST_EXEC);
    assign start = w_cmd && (state == cal_pkg::CAL_ST_IDLE);

    always_comb begin
        hit = 1'b1;
        rd_val = `CAL_K_ZERO;
        if (paddr == `CAL_A_SRC) begin
            rd_val = src;
        end else if (paddr == `CAL_A_DST) begin
            rd_val = dst;
        end else if (paddr == `CAL_A_CMD) begin
            rd_val = {7'h00, (state != cal_pkg::CAL_ST_IDLE), 3'h0, cmd};
        end else if (paddr == `CAL_A_SW) begin
            rd_val = sw;
        end else if (paddr == `CAL_A_PC) begin
            rd_val = pc;
        end else if (paddr == `CAL_A_SP) begin
            rd_val = sp;
        end else begin
            hit = 1'b0;
        end
    end

    // one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            prdata  <= {16'h0000, rd_val};
            pslverr <= ~hit;
        end
    end

    // ----------------------------------------
    // operand mapping
    // ----------------------------------------
    always_comb begin
        alu_cmd = cmd;
        alu_a = src;
        alu_b = dst;
        to_sw = 1'b0;
        case (cmd.op)
            cal_pkg::CAL_OP_ZERO: begin
                alu_cmd.op = cal_pkg::CAL_OP_COPY;
                alu_a = `CAL_K_ZERO;
            end
            cal_pkg::CAL_OP_CCLR: begin
                alu_cmd = '{byte_sel: 1'b0, op: cal_pkg::CAL_OP_BCLR};
                alu_a = `CAL_K_CMSK;
                alu_b = sw;
                to_sw = 1'b1;
            end
            cal_pkg::CAL_OP_NCLR: begin
                alu_cmd = '{byte_sel: 1'b0, op: cal_pkg::CAL_OP_BCLR};
                alu_a = `CAL_K_NMSK;
                alu_b = sw;
                to_sw = 1'b1;
            end
            cal_pkg::CAL_OP_JUMP: begin
                alu_cmd = '{byte_sel: 1'b0, op: cal_pkg::CAL_OP_COPY};
                alu_b = pc;
            end
            default: ;
        endcase
    end

    cal_alu u_alu (
        .cmd (alu_cmd),
        .a   (alu_a),
        .b   (alu_b),
        .cin (sw[`CAL_SW_C]),
        .out (alu)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            cal_pkg::CAL_ST_IDLE: begin
                if (start) begin
                    if (cal_pkg::cal_op_t'(pwdata[3:0]) == cal_pkg::CAL_OP_CALL) begin
                        next_state = cal_pkg::CAL_ST_DEC;
                    end else begin
                        next_state = cal_pkg::CAL_ST_EXEC;
                    end
                end
            end
            cal_pkg::CAL_ST_DEC:  next_state = cal_pkg::CAL_ST_PUSH;
            cal_pkg::CAL_ST_PUSH: next_state = cal_pkg::CAL_ST_LOAD;
            default:              next_state = cal_pkg::CAL_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= cal_pkg::CAL_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= '{byte_sel: 1'b0, op: cal_pkg::CAL_OP_COPY};
        end else if (start) begin
            cmd <= cal_pkg::cal_cmd_t'(pwdata[4:0]);
        end
    end

    // ----------------------------------------
    // register writes, execution wins
    // ----------------------------------------
    // source only written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src <= `CAL_RST_W;
        end else if (w_src) begin
            src <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst <= `CAL_RST_W;
        end else if (ex && alu.dst_we && !to_sw && cmd.op != cal_pkg::CAL_OP_JUMP) begin
            dst <= alu.res;
        end else if (w_dst) begin
            dst <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw <= `CAL_RST_W;
        end else if (ex && to_sw) begin
            sw <= alu.res;
        end else if (ex && alu.flag_we) begin
            sw[`CAL_SW_N] <= alu.n;
            sw[`CAL_SW_Z] <= alu.z;
            sw[`CAL_SW_C] <= alu.c;
            sw[`CAL_SW_V] <= alu.v;
        end else if (w_sw) begin
            sw <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmp <= `CAL_RST_W;
        end else if (start) begin
            tmp <= src;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= `CAL_RST_W;
        end else if (state == cal_pkg::CAL_ST_DEC) begin
            sp <= sp - `CAL_SP_STEP;
        end else if (w_sp) begin
            sp <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= `CAL_RST_W;
        end else if (ex && cmd.op == cal_pkg::CAL_OP_JUMP) begin
            pc <= alu.res;
        end else if (state == cal_pkg::CAL_ST_LOAD) begin
            pc <= tmp;
        end else if (w_pc) begin
            pc <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_we   <= 1'b0;
            stack_addr <= `CAL_RST_W;
            stack_data <= `CAL_RST_W;
        end else begin
            stack_we <= (state == cal_pkg::CAL_ST_PUSH);
            if (state == cal_pkg::CAL_ST_PUSH) begin
                stack_addr <= sp;
                stack_data <= pc;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [16:0] add_chk;
    logic [15:0] sum_with_carry_in_chk;
    logic        add_co;
    logic [2:0]  mode;

    assign add_chk  = {1'b0, src} + {1'b0, dst};
    assign add_co   = add_chk[16];
    assign sum_with_carry_in_chk = src + dst + {15'h0000, sw[`CAL_SW_C]};
    assign mode     = {sw[`CAL_SW_OSC], sw[`CAL_SW_HLT], sw[`CAL_SW_IE]};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_add_sum;
        ex && cmd.op == cal_pkg::CAL_OP_ADD && !cmd.byte_sel |=>
            dst == $past(add_chk[15:0]) && sw[`CAL_SW_C] == $past(add_co);
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("sum wrong");

    property p_src_kept;
        ex && !w_src |=> $stable(src);
    endproperty
    a_src_kept: assert property (p_src_kept) else $error("source altered");

    property p_sum_with_carry_in;
        ex && cmd.op == cal_pkg::CAL_OP_ADDCI && !cmd.byte_sel |=> dst == $past(sum_with_carry_in_chk);
    endproperty
    a_sum_with_carry_in: assert property (p_sum_with_carry_in) else $error("carry sum wrong");

    property p_and_c;
        ex && (cmd.op == cal_pkg::CAL_OP_AND || cmd.op == cal_pkg::CAL_OP_BIT) |=>
            sw[`CAL_SW_C] == !sw[`CAL_SW_Z] && !sw[`CAL_SW_V];
    endproperty
    a_and_c: assert property (p_and_c) else $error("and flags wrong");

    property p_bit_keep;
        ex && cmd.op == cal_pkg::CAL_OP_BIT && !w_dst |=> $stable(dst);
    endproperty
    a_bit_keep: assert property (p_bit_keep) else $error("test wrote dst");

    property p_bcbs;
        ex && (cmd.op == cal_pkg::CAL_OP_BCLR || cmd.op == cal_pkg::CAL_OP_BSET) && !w_sw
            |=> $stable(sw);
    endproperty
    a_bcbs: assert property (p_bcbs) else $error("bit op moved flags");

    property p_mode;
        ex && !w_sw |=> $stable(mode);
    endproperty
    a_mode: assert property (p_mode) else $error("mode bits altered");

    property p_jump;
        ex && cmd.op == cal_pkg::CAL_OP_JUMP |=> pc == $past(src);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    sequence s_call;
        state == cal_pkg::CAL_ST_DEC ##1
        state == cal_pkg::CAL_ST_PUSH && !stack_we ##1
        state == cal_pkg::CAL_ST_LOAD && stack_we && stack_data == $past(pc) ##1
        state == cal_pkg::CAL_ST_IDLE && pc == $past(tmp);
    endsequence

    property p_call;
        state == cal_pkg::CAL_ST_DEC && !w_pc |-> s_call;
    endproperty
    a_call: assert property (p_call) else $error("call order wrong");

    property p_push_addr;
        state == cal_pkg::CAL_ST_DEC && !w_sp |=> ##1 stack_addr == $past(sp, 2) - `CAL_SP_STEP;
    endproperty
    a_push_addr: assert property (p_push_addr) else $error("push address wrong");

    property p_cclr;
        ex && cmd.op == cal_pkg::CAL_OP_CCLR |=> sw == ($past(sw) & ~`CAL_K_CMSK);
    endproperty
    a_cclr: assert property (p_cclr) else $error("carry clear wrong");

    property p_nclr;
        ex && cmd.op == cal_pkg::CAL_OP_NCLR |=> sw == ($past(sw) & ~`CAL_K_NMSK);
    endproperty
    a_nclr: assert property (p_nclr) else $error("negative clear wrong");

    property p_zero;
        ex && cmd.op == cal_pkg::CAL_OP_ZERO && !w_sw |=> dst == `CAL_K_ZERO && $stable(sw);
    endproperty
    a_zero: assert property (p_zero) else $error("zero dst wrong");

    property p_byte_n;
        ex && cmd.op == cal_pkg::CAL_OP_ADD && cmd.byte_sel |=>
            sw[`CAL_SW_N] == dst[7] && dst[15:8] == 8'h00;
    endproperty
    a_byte_n: assert property (p_byte_n) else $error("byte flag wrong");

endmodule

`default_nettype wire

// ---- cal_core_tb.sv ----
/*
 * Self-checking bench of the add/logic/branch unit: APB read and
 * write tasks, operation checks against a bench-side model.
 * Assumes cal_core answers APB with pready and drives stack strobes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cal_params.svh"

module cal_core_tb;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        stack_we;
    logic [15:0] stack_addr;
    logic [15:0] stack_data;
    int          num_errors;
    int          total_checks;
    int          pushes;
    logic [15:0] push_addr;
    logic [15:0] push_data;

    cal_core u_dut (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .stack_we   (stack_we),
        .stack_addr (stack_addr),
        .stack_data (stack_data)
    );

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    // ----------------------------------------
    // stack write monitor
    // ----------------------------------------
    always @(posedge pclk) begin
        if (stack_we === 1'b1) begin
            pushes = pushes + 1;
            push_addr = stack_addr;
            push_data = stack_data;
        end
    end

    // ----------------------------------------
    // verdict and helpers
    // ----------------------------------------
    task automatic close_out();
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // hold until pready, watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, {16'h0000, d}, x, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask

    task automatic run(input cal_pkg::cal_op_t op, input logic b);
        logic [31:0] d;
        wr(`CAL_A_CMD, {11'h000, b, op});
        // poll busy, watchdog ends a hang
        do begin
            rd(`CAL_A_CMD, d);
        end while (d[8] !== 1'b0);
    endtask

    // ----------------------------------------
    // operation with expected result and flags
    // ----------------------------------------
    task automatic check_op(input cal_pkg::cal_op_t op, input logic b,
                            input logic [15:0] s, input logic [15:0] d, input logic [15:0] sw);
        logic [16:0] w;
        logic [15:0] r;
        logic [15:0] f;
        logic [15:0] m;
        logic [31:0] x;
        logic        cin;
        logic        n;
        logic        z;
        logic        c;
        logic        v;
        logic        upd;
        r = d;
        f = sw;
        upd = 1'b0;
        cin = (op == cal_pkg::CAL_OP_ADDCI) ? sw[`CAL_SW_C] : 1'b0;
        m = s & d;
        if (b) m[15:8] = 8'h00;
        case (op)
            cal_pkg::CAL_OP_ADD, cal_pkg::CAL_OP_ADDCI: begin
                w = b ? ({9'h000, s[7:0]} + {9'h000, d[7:0]} + 17'(cin)) : ({1'b0, s} + {1'b0, d} + 17'(cin));
                r = w[15:0];
                if (b) r[15:8] = 8'h00;
                c = b ? w[8] : w[16];
                n = b ? r[7] : r[15];
                z = (r == 16'h0000);
                v = b ? (s[7] == d[7] && r[7] != s[7]) : (s[15] == d[15] && r[15] != s[15]);
                upd = 1'b1;
            end
            cal_pkg::CAL_OP_AND, cal_pkg::CAL_OP_BIT: begin
                if (op == cal_pkg::CAL_OP_AND) r = m;
                n = b ? m[7] : m[15];
                z = (m == 16'h0000);
                c = !z;
                v = 1'b0;
                upd = 1'b1;
            end
            cal_pkg::CAL_OP_BCLR: r = ~s & d;
            cal_pkg::CAL_OP_BSET: r = s | d;
            cal_pkg::CAL_OP_COPY: r = s;
            cal_pkg::CAL_OP_ZERO: r = 16'h0000;
            cal_pkg::CAL_OP_CCLR: f = sw & 16'hFFFE;
            cal_pkg::CAL_OP_NCLR: f = sw & 16'hFFFB;
            default: ;
        endcase
        if (b && op inside {cal_pkg::CAL_OP_BCLR, cal_pkg::CAL_OP_BSET, cal_pkg::CAL_OP_COPY}) r[15:8] = 8'h00;
        if (upd) f = {sw[15:9], v, sw[7:3], n, z, c};
        wr(`CAL_A_SRC, s);
        wr(`CAL_A_DST, d);
        wr(`CAL_A_SW, sw);
        run(op, b);
        rd(`CAL_A_DST, x);
        chk("dst", {16'h0000, r}, x);
        rd(`CAL_A_SW, x);
        chk("status_word", {16'h0000, f}, x);
        rd(`CAL_A_SRC, x);
        chk("src", {16'h0000, s}, x);
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        close_out();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] x;
        logic        e;
        int          i;
        int          p0;
        num_errors = 0;
        total_checks = 0;
        pushes = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(8'(i * 4), x);
            chk("reset_value", 32'h0000_0000, x);
        end
        apb(1'b0, 8'h18, 32'h0000_0000, x, e);
        chk("unmapped_err", 32'h0000_0001, {31'h0, e});
        chk("unmapped_data", 32'h0000_0000, x);
        check_op(cal_pkg::CAL_OP_ADD, 1'b0, 16'h0001, 16'h7FFF, 16'h0038);
        check_op(cal_pkg::CAL_OP_ADD, 1'b0, 16'h0001, 16'hFFFF, 16'h0038);
        check_op(cal_pkg::CAL_OP_ADD, 1'b0, 16'h8000, 16'h8000, 16'h0107);
        check_op(cal_pkg::CAL_OP_ADD, 1'b1, 16'h12F0, 16'h0410, 16'h0038);
        check_op(cal_pkg::CAL_OP_ADD, 1'b1, 16'h0001, 16'hFF7F, 16'h0038);
        check_op(cal_pkg::CAL_OP_ADDCI, 1'b0, 16'h0001, 16'h0002, 16'h0039);
        check_op(cal_pkg::CAL_OP_ADDCI, 1'b0, 16'h0000, 16'hFFFF, 16'h0039);
        check_op(cal_pkg::CAL_OP_ADDCI, 1'b0, 16'h0000, 16'hFFFF, 16'h0038);
        check_op(cal_pkg::CAL_OP_ADDCI, 1'b1, 16'h00FF, 16'h0000, 16'h0039);
        check_op(cal_pkg::CAL_OP_AND, 1'b0, 16'hAA55, 16'h8F00, 16'h0138);
        check_op(cal_pkg::CAL_OP_AND, 1'b0, 16'h00FF, 16'hFF00, 16'h0038);
        check_op(cal_pkg::CAL_OP_AND, 1'b1, 16'hFFA5, 16'h80F0, 16'h0038);
        check_op(cal_pkg::CAL_OP_BIT, 1'b0, 16'h0200, 16'h0200, 16'h0138);
        check_op(cal_pkg::CAL_OP_BIT, 1'b1, 16'h0008, 16'h0F00, 16'h0039);
        check_op(cal_pkg::CAL_OP_BCLR, 1'b0, 16'hFC00, 16'hFFFF, 16'h013F);
        check_op(cal_pkg::CAL_OP_BCLR, 1'b1, 16'h00F8, 16'h1234, 16'h0000);
        check_op(cal_pkg::CAL_OP_BSET, 1'b0, 16'h003F, 16'h8000, 16'h0107);
        check_op(cal_pkg::CAL_OP_BSET, 1'b1, 16'h00E0, 16'h0001, 16'h0038);
        check_op(cal_pkg::CAL_OP_COPY, 1'b0, 16'hBEEF, 16'h1234, 16'h0107);
        check_op(cal_pkg::CAL_OP_ZERO, 1'b0, 16'h5555, 16'hFFFF, 16'h013F);
        check_op(cal_pkg::CAL_OP_ZERO, 1'b1, 16'h5555, 16'hFFFF, 16'h0000);
        check_op(cal_pkg::CAL_OP_CCLR, 1'b0, 16'h0000, 16'h4321, 16'h013F);
        check_op(cal_pkg::CAL_OP_NCLR, 1'b0, 16'h0000, 16'h4321, 16'h013F);
        wr(`CAL_A_PC, 16'h1234);
        wr(`CAL_A_SW, 16'h013F);
        wr(`CAL_A_SRC, 16'hFFFE);
        run(cal_pkg::CAL_OP_JUMP, 1'b0);
        rd(`CAL_A_PC, x);
        chk("jump_pc", 32'h0000_FFFE, x);
        rd(`CAL_A_SW, x);
        chk("jump_status_word", 32'h0000_013F, x);
        wr(`CAL_A_SP, 16'h0400);
        wr(`CAL_A_PC, 16'h2002);
        wr(`CAL_A_SRC, 16'hC000);
        p0 = pushes;
        run(cal_pkg::CAL_OP_CALL, 1'b0);
        chk("call_pushes", 32'h0000_0001, 32'(pushes - p0));
        chk("call_push_addr", 32'h0000_03FE, {16'h0000, push_addr});
        chk("call_push_data", 32'h0000_2002, {16'h0000, push_data});
        rd(`CAL_A_SP, x);
        chk("call_sp", 32'h0000_03FE, x);
        rd(`CAL_A_PC, x);
        chk("call_pc", 32'h0000_C000, x);
        rd(`CAL_A_SW, x);
        chk("call_status_word", 32'h0000_013F, x);
        close_out();
    end

endmodule

`default_nettype wire
